// File: core/tsw_pkg.sv
/*
  Shared constants, carrier structs and helpers for the timer set with wake-up.
  Assumes a single 25 MHz system clock and a synchronous active-high reset.
*/
package tsw_pkg;

  // system clock and tick rates, in Hz
  localparam int unsigned SYS_HZ = 25000000;
  localparam int unsigned GPT_FAST_HZ = 4000000;
  localparam int unsigned GPT_SLOW_HZ = 32768;
  localparam int unsigned CNT_HZ = 16000000;

  // wake-up timing: the calibration step is 1/256 s
  localparam int unsigned CAL_STEP_HZ = 256;
  localparam int unsigned CAL_WINDOW_CYCLES = SYS_HZ / CAL_STEP_HZ;
  localparam int unsigned SLOW_OSC_HZ = 32768;
  localparam logic [15:0] CAL_RESET = 16'(SLOW_OSC_HZ / CAL_STEP_HZ);
  localparam int unsigned WAKE_SHORT_S = 2;
  localparam int unsigned WAKE_LONG_S = 256;
  localparam int unsigned WAKE_STEPS = 256;
  localparam logic [8:0] WAKE_SHORT_UNIT = 9'(WAKE_SHORT_S * CAL_STEP_HZ / WAKE_STEPS);
  localparam logic [8:0] WAKE_LONG_UNIT = 9'(WAKE_LONG_S * CAL_STEP_HZ / WAKE_STEPS);

  // counter modes, classic numbering
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;
  localparam logic [12:0] MAX_13 = 13'h1fff;
  localparam logic [15:0] MAX_16 = 16'hffff;
  localparam logic [7:0] MAX_8 = 8'hff;

  // one-hot states
  typedef enum logic [1:0] {TSW_PWM_HIGH = 2'b01, TSW_PWM_LOW = 2'b10} tsw_pwm_state_t;
  typedef enum logic [1:0] {TSW_WAKE_IDLE = 2'b01, TSW_WAKE_RUN = 2'b10} tsw_wake_state_t;

  // control and status of one 16-bit counter
  typedef struct packed {
    logic run;
    logic event_mode;
    logic [1:0] mode;
    logic load;
    logic [15:0] load_value;
    logic flag_clear;
  } tsw_cnt_ctl_t;

  typedef struct packed {
    logic [15:0] count;
    logic overflow;
    logic irq;
  } tsw_cnt_sts_t;

  // fractional rate generator: returns {tick, next accumulator}
  function automatic logic [32:0] tsw_rate_step(input logic [31:0] acc, input logic [31:0] inc);
    logic [31:0] sum;
    sum = acc + inc;
    if (sum >= SYS_HZ) begin
      tsw_rate_step = {1'b1, sum - SYS_HZ};
    end else begin
      tsw_rate_step = {1'b0, sum};
    end
  endfunction : tsw_rate_step

endpackage : tsw_pkg

// File: core/tsw_counter.sv
/*
  One 16-bit interval/event counter with overflow flag and interrupt request.
  Assumes a 16 MHz average tick from the parent and an asynchronous event pin.
*/
`timescale 1ns/1ns
module tsw_counter (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // count sources
  input wire logic tick16,
  input wire logic event_pin,
  // control and status
  input wire tsw_pkg::tsw_cnt_ctl_t ctl,
  output tsw_pkg::tsw_cnt_sts_t sts
);
  import tsw_pkg::*;

  logic [2:0] sync_reg;
  logic stable_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic flag_reg;
  logic irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // event pin synchroniser; a change counts once stages two and three agree
  wire agree = (sync_reg[1] == sync_reg[2]);
  wire fall = agree & stable_reg & ~sync_reg[2]; // see R11

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_reg <= 3'h7;
      stable_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], event_pin};
      stable_reg <= agree ? sync_reg[2] : stable_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count step; no gate input exists, run alone enables counting
  wire inc = ctl.run & (ctl.event_mode ? fall : tick16); // see R6, R7
  wire wrap13 = (count_reg[12:0] == MAX_13);
  wire wrap16 = (count_reg == MAX_16);
  wire wrap8 = (count_reg[7:0] == MAX_8);
  wire wrap = inc & ((ctl.mode == MODE_13BIT) ? wrap13 :
                     (ctl.mode == MODE_16BIT) ? wrap16 :
                     (ctl.mode == MODE_8BIT_RELOAD) ? wrap8 : 1'b0); // see R12

  always_comb begin
    count_next = count_reg;
    if (ctl.load) begin
      count_next = ctl.load_value;
    end else if (inc) begin
      unique case (ctl.mode)
        MODE_13BIT: count_next = {3'h0, 13'(count_reg[12:0] + 13'h1)};
        MODE_16BIT: count_next = count_reg + 16'h1; // see R5
        MODE_8BIT_RELOAD: count_next = {count_reg[15:8], wrap8 ? count_reg[15:8] : 8'(count_reg[7:0] + 8'h1)};
        MODE_HOLD: count_next = count_reg; // mode 3 simply holds here
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag and request: a wrap in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= 16'h0;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      flag_reg <= wrap | (flag_reg & ~ctl.flag_clear); // see R12
      irq_reg <= wrap | (irq_reg & ~ctl.flag_clear);
    end
  end

  assign sts = '{count: count_reg, overflow: flag_reg, irq: irq_reg};

endmodule : tsw_counter

// File: core/tsw_timer_set.sv
/*
  Timer set: auto-reload general purpose timer with PWM, two 16-bit
  interval/event counters and a self-calibrating sleep wake timer.
  Assumes control bits arrive from the CPU side on the same clock, and that
  the slow oscillator and event pins are asynchronous.
*/
// How it works
// R1 - general timer counts up 16 bits, reloads start value on every wrap
// R2 - general timer ticks at 4 MHz or about 32 kHz, selectable
// R3 - each wrap sets a status flag and, if enabled, an interrupt request
// R4 - PWM output high and low for two separate 8-bit period settings
// R5 - two independent 16-bit counters, each timer or event counter
// R6 - counters count 16 MHz in interval mode or own pin in event mode
// R7 - classic counter modes, but no external gate input
// R8 - wake timer wakes the sleeping device after zero to 256 seconds (here at most 255 s, wake value 255 in the 256 s range)
// R9 - 8-bit wake value scaled as fraction of 2 s or 256 s
// R10 - wake time base recalibrates against system clock, error under 1%
// R11 - event input synchronised, one count per high-to-low transition
// R12 - each counter sets overflow flag and own request on rollover
`timescale 1ns/1ns
module tsw_timer_set #(
  parameter int unsigned CAL_CYCLES = tsw_pkg::CAL_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // general purpose timer control
  input wire logic [15:0] gpt_reload,
  input wire logic gpt_run,
  input wire logic gpt_slow_rate,
  input wire logic gpt_irq_enable,
  input wire logic gpt_flag_clear,
  input wire logic pwm_enable,
  input wire logic [7:0] pwm_high_period,
  input wire logic [7:0] pwm_low_period,
  // general purpose timer status and pin
  output logic [15:0] gpt_count,
  output logic gpt_flag,
  output logic gpt_irq,
  output logic pwm_output_pin,
  // counters a and b
  input wire logic counter_a_event_pin,
  input wire logic counter_b_event_pin,
  input wire tsw_pkg::tsw_cnt_ctl_t counter_a_ctl,
  input wire tsw_pkg::tsw_cnt_ctl_t counter_b_ctl,
  output tsw_pkg::tsw_cnt_sts_t counter_a_sts,
  output tsw_pkg::tsw_cnt_sts_t counter_b_sts,
  // sleep wake timer
  input wire logic slow_osc_pin,
  input wire logic wake_start,
  input wire logic [7:0] wake_value,
  input wire logic wake_long_range,
  output logic wake_event,
  output logic wake_busy,
  output logic [15:0] wake_cal
);
  import tsw_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // rate generators
  logic [31:0] fast_acc_reg;
  logic [31:0] slow_acc_reg;
  logic [31:0] cnt_acc_reg;
  wire [32:0] fast_step = tsw_rate_step(fast_acc_reg, GPT_FAST_HZ);
  wire [32:0] slow_step = tsw_rate_step(slow_acc_reg, GPT_SLOW_HZ);
  wire [32:0] cnt_step = tsw_rate_step(cnt_acc_reg, CNT_HZ);
  // the ticks jitter by one cycle but average exactly to the nominal rate
  wire gpt_tick = gpt_slow_rate ? slow_step[32] : fast_step[32]; // see R2

  always_ff @(posedge clock) begin
    if (rst) begin
      fast_acc_reg <= 32'h0;
      slow_acc_reg <= 32'h0;
      cnt_acc_reg <= 32'h0;
    end else begin
      fast_acc_reg <= fast_step[31:0];
      slow_acc_reg <= slow_step[31:0];
      cnt_acc_reg <= cnt_step[31:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general purpose timer with auto-reload
  logic [15:0] gpt_count_reg;
  logic gpt_flag_reg;
  logic gpt_irq_reg;
  wire gpt_inc = gpt_run & gpt_tick;
  wire gpt_wrap = gpt_inc & (gpt_count_reg == MAX_16);
  // a stopped timer sits at its start value, so the first interval is full length too
  wire [15:0] gpt_count_next = ~gpt_run ? gpt_reload :
                               ~gpt_inc ? gpt_count_reg :
                               gpt_wrap ? gpt_reload : gpt_count_reg + 16'h1; // see R1

  // set wins over clear for flag and request
  always_ff @(posedge clock) begin
    if (rst) begin
      gpt_count_reg <= 16'h0;
      gpt_flag_reg <= 1'b0;
      gpt_irq_reg <= 1'b0;
    end else begin
      gpt_count_reg <= gpt_count_next;
      gpt_flag_reg <= gpt_wrap | (gpt_flag_reg & ~gpt_flag_clear); // see R3
      gpt_irq_reg <= (gpt_wrap & gpt_irq_enable) | (gpt_irq_reg & ~gpt_flag_clear); // see R3
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pwm phases, each lasting its period in timer ticks (zero acts as one)
  tsw_pwm_state_t pwm_state_reg;
  logic [7:0] pwm_phase_reg;
  logic pwm_pin_reg;
  wire [7:0] pwm_period = (pwm_state_reg == TSW_PWM_HIGH) ? pwm_high_period : pwm_low_period;
  wire pwm_done = gpt_tick & (8'(pwm_phase_reg + 8'h1) >= pwm_period);
  wire pwm_to_low = pwm_done & (pwm_state_reg == TSW_PWM_HIGH);

  always_ff @(posedge clock) begin
    if (rst | ~pwm_enable) begin
      pwm_state_reg <= TSW_PWM_HIGH;
      pwm_phase_reg <= 8'h0;
      pwm_pin_reg <= 1'b0;
    end else begin
      pwm_state_reg <= pwm_done ? (pwm_to_low ? TSW_PWM_LOW : TSW_PWM_HIGH) : pwm_state_reg; // see R4
      pwm_phase_reg <= pwm_done ? 8'h0 : (gpt_tick ? 8'(pwm_phase_reg + 8'h1) : pwm_phase_reg);
      pwm_pin_reg <= pwm_done ? pwm_to_low ^ 1'b1 : (pwm_state_reg == TSW_PWM_HIGH); // see R4
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // the two 16-bit counters
  tsw_counter u_counter_a (
    .clock(clock),
    .rst(rst),
    .tick16(cnt_step[32]),
    .event_pin(counter_a_event_pin),
    .ctl(counter_a_ctl),
    .sts(counter_a_sts)
  ); // see R5

  tsw_counter u_counter_b (
    .clock(clock),
    .rst(rst),
    .tick16(cnt_step[32]),
    .event_pin(counter_b_event_pin),
    .ctl(counter_b_ctl),
    .sts(counter_b_sts)
  ); // see R5

  //////////////////////////////////////////////////////////////////////////////
  // slow oscillator synchroniser and rising-edge detect
  logic [2:0] osc_sync_reg;
  logic osc_stable_reg;
  wire osc_agree = (osc_sync_reg[1] == osc_sync_reg[2]);
  wire osc_rise = osc_agree & ~osc_stable_reg & osc_sync_reg[2];

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_sync_reg <= 3'h0;
      osc_stable_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], slow_osc_pin};
      osc_stable_reg <= osc_agree ? osc_sync_reg[2] : osc_stable_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // calibration: slow edges per 1/256 s of system clock, refreshed each window
  logic [31:0] cal_win_reg;
  logic [15:0] cal_edges_reg;
  logic [15:0] cal_reg;
  wire cal_end = (cal_win_reg == 32'(CAL_CYCLES - 1));
  // a slow edge on the window boundary opens the next count
  wire [15:0] cal_edges_next = cal_end ? {15'h0, osc_rise} : cal_edges_reg + {15'h0, osc_rise};

  always_ff @(posedge clock) begin
    if (rst) begin
      cal_win_reg <= 32'h0;
      cal_edges_reg <= 16'h0;
      cal_reg <= CAL_RESET;
    end else begin
      cal_win_reg <= cal_end ? 32'h0 : cal_win_reg + 32'h1;
      cal_edges_reg <= cal_edges_next;
      if (cal_end) begin
        cal_reg <= (cal_edges_reg == 16'h0) ? CAL_RESET : cal_edges_reg; // see R10
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake countdown: slow edges -> 1/256 s steps -> units of 2/256 s or 1 s
  tsw_wake_state_t wake_state_reg;
  logic [15:0] step_cnt_reg;
  logic [8:0] unit_cnt_reg;
  logic [7:0] remain_reg;
  logic wake_event_reg;
  wire [8:0] unit_len = wake_long_range ? WAKE_LONG_UNIT : WAKE_SHORT_UNIT; // see R9
  wire step_tick = osc_rise & (16'(step_cnt_reg + 16'h1) >= cal_reg);
  wire unit_tick = step_tick & (9'(unit_cnt_reg + 9'h1) >= unit_len);
  wire running = (wake_state_reg == TSW_WAKE_RUN);
  wire wake_fire = (wake_start & (wake_value == 8'h0)) |
                   (running & unit_tick & (remain_reg == 8'h1)); // see R8

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_state_reg <= TSW_WAKE_IDLE;
      step_cnt_reg <= 16'h0;
      unit_cnt_reg <= 9'h0;
      remain_reg <= 8'h0;
      wake_event_reg <= 1'b0;
    end else begin
      wake_event_reg <= wake_fire;
      if (wake_start) begin
        wake_state_reg <= (wake_value == 8'h0) ? TSW_WAKE_IDLE : TSW_WAKE_RUN;
        remain_reg <= wake_value; // see R9
        step_cnt_reg <= 16'h0;
        unit_cnt_reg <= 9'h0;
      end else if (running) begin
        step_cnt_reg <= step_tick ? 16'h0 : step_cnt_reg + {15'h0, osc_rise};
        unit_cnt_reg <= unit_tick ? 9'h0 : unit_cnt_reg + {8'h0, step_tick};
        remain_reg <= remain_reg - {7'h0, unit_tick};
        wake_state_reg <= wake_fire ? TSW_WAKE_IDLE : TSW_WAKE_RUN; // see R8
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops except wake_busy, decoded from the wake state
  assign gpt_count = gpt_count_reg;
  assign gpt_flag = gpt_flag_reg;
  assign gpt_irq = gpt_irq_reg;
  assign pwm_output_pin = pwm_pin_reg;
  assign wake_event = wake_event_reg;
  assign wake_busy = running;
  assign wake_cal = cal_reg;

endmodule : tsw_timer_set

// File: sim/tsw_timer_set_properties.sv
/*
  Port-level timing checks for the timer set.
  Assumes binding into tsw_timer_set, one clock, synchronous reset.
*/
`timescale 1ns/1ns
module tsw_timer_set_properties
  import tsw_pkg::*;
  #(parameter int unsigned CAL_CYCLES = CAL_WINDOW_CYCLES) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // general timer and pin
  input wire logic [15:0] gpt_reload,
  input wire logic gpt_run,
  input wire logic gpt_irq_enable,
  input wire logic [15:0] gpt_count,
  input wire logic gpt_flag,
  input wire logic gpt_irq,
  input wire logic pwm_enable,
  input wire logic pwm_output_pin,
  // counters
  input wire tsw_cnt_ctl_t counter_a_ctl,
  input wire tsw_cnt_ctl_t counter_b_ctl,
  input wire tsw_cnt_sts_t counter_a_sts,
  input wire tsw_cnt_sts_t counter_b_sts,
  // wake timer
  input wire logic wake_start,
  input wire logic [7:0] wake_value,
  input wire logic wake_event,
  input wire logic wake_busy,
  input wire logic [15:0] wake_cal
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  // general timer: the past-reset term guards a one-cycle reset
  property p_wrap;
    !$past(rst) && $past(gpt_run) && $past(gpt_count) == MAX_16 && gpt_count != MAX_16
      |-> gpt_count == $past(gpt_reload) && gpt_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer wrap wrong");
  property p_step;
    !$past(rst) && $past(gpt_run) && gpt_count != $past(gpt_count) && $past(gpt_count) != MAX_16
      |-> gpt_count == $past(gpt_count) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("timer step wrong");
  property p_rate;
    // a preload while stopped is not a count step
    $past(gpt_run) && gpt_count != $past(gpt_count) |=> (!$past(gpt_run) || $stable(gpt_count))[*5];
  endproperty
  a_rate: assert property (p_rate) else $error("timer too fast");
  property p_irq;
    $rose(gpt_irq) |-> $past(gpt_irq_enable) && gpt_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("timer request wrong");
  property p_pwm_off;
    !pwm_enable |=> !pwm_output_pin;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm pin not low");

  ////////////////////////////////////////////////////////////////
  // counters
  property p_roll;
    !$past(rst) && $past(counter_a_sts.count) == MAX_16 && counter_a_sts.count == 16'h0 && !$past(counter_a_ctl.load)
      |-> counter_a_sts.overflow && counter_a_sts.irq;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover flags wrong");
  property p_sticky;
    counter_a_sts.overflow && !counter_a_ctl.flag_clear |=> counter_a_sts.overflow;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow lost");
  property p_stop;
    !$past(rst) && !$past(counter_b_ctl.run) && !$past(counter_b_ctl.load) |-> $stable(counter_b_sts.count);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_hold;
    !$past(rst) && $past(counter_a_ctl.mode) == MODE_HOLD && !$past(counter_a_ctl.load) |-> $stable(counter_a_sts.count);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode moved");

  ////////////////////////////////////////////////////////////////
  // wake timer
  property p_pulse;
    wake_event |=> !wake_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse too long");
  property p_zero;
    wake_start && wake_value == 8'h0 |=> wake_event && !wake_busy;
  endproperty
  a_zero: assert property (p_zero) else $error("zero wake wrong");
  property p_drop;
    $fell(wake_busy) |-> wake_event;
  endproperty
  a_drop: assert property (p_drop) else $error("busy fell alone");
  property p_cal;
    wake_cal != $past(wake_cal) |=> $stable(wake_cal)[*8];
  endproperty
  a_cal: assert property (p_cal) else $error("calibration jumped");
endmodule : tsw_timer_set_properties

bind tsw_timer_set tsw_timer_set_properties #(.CAL_CYCLES(CAL_CYCLES)) u_props (.clock, .rst, .gpt_reload, .gpt_run,
  .gpt_irq_enable, .gpt_count, .gpt_flag, .gpt_irq, .pwm_enable, .pwm_output_pin, .counter_a_ctl, .counter_b_ctl,
  .counter_a_sts, .counter_b_sts, .wake_start, .wake_value, .wake_event, .wake_busy, .wake_cal);

// File: sim/tsw_timer_set_test.sv
/*
  Self-checking bench for the timer set, driven at the falling edge.
  Assumes the package and design compiled first; slow oscillator is fast here.
*/
`timescale 1ns/1ns
module tsw_timer_set_test;
  import tsw_pkg::*;
  localparam int unsigned CAL = 200;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] gpt_reload = 16'h8000;
  logic gpt_run = 1'b0, gpt_slow_rate = 1'b0, gpt_irq_enable = 1'b1, gpt_flag_clear = 1'b0, pwm_enable = 1'b0;
  logic [7:0] pwm_high_period = 8'h3, pwm_low_period = 8'h5, wake_value = 8'h0;
  logic counter_a_event_pin = 1'b1, counter_b_event_pin = 1'b1, slow_osc_pin = 1'b0;
  logic wake_start = 1'b0, wake_long_range = 1'b0;
  tsw_cnt_ctl_t counter_a_ctl = '0, counter_b_ctl = '0;
  logic [15:0] gpt_count, wake_cal, c;
  logic gpt_flag, gpt_irq, pwm_output_pin, wake_event, wake_busy;
  tsw_cnt_sts_t counter_a_sts, counter_b_sts;
  logic [15:0] mv [3] = '{16'h1ff8, 16'hfff0, 16'h40f8};
  logic [15:0] me [3] = '{16'h0, 16'h0, 16'h4000};
  int fails = 0, total_checks = 0, n;

  tsw_timer_set #(.CAL_CYCLES(CAL)) dut (.clock, .rst, .gpt_reload, .gpt_run, .gpt_slow_rate, .gpt_irq_enable,
    .gpt_flag_clear, .pwm_enable, .pwm_high_period, .pwm_low_period, .gpt_count, .gpt_flag, .gpt_irq,
    .pwm_output_pin, .counter_a_event_pin, .counter_b_event_pin, .counter_a_ctl, .counter_b_ctl, .counter_a_sts,
    .counter_b_sts, .slow_osc_pin, .wake_start, .wake_value, .wake_long_range, .wake_event, .wake_busy, .wake_cal);

  ////////////////////////////////////////////////////////////////
  // clocks: slow oscillator offset so its edges never meet ours
  always #20 clock = ~clock;
  initial begin
    #7;
    forever #200 slow_osc_pin = ~slow_osc_pin;
  end

  ////////////////////////////////////////////////////////////////
  // compare and drive helpers
  task automatic bad(input logic [15:0] got, input logic [15:0] exp);
    fails++;
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
  endtask : bad
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) bad(got, exp);
  endtask : chk
  // tolerant compare: rate generators jitter by a tick
  task automatic near(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    total_checks++;
    if (^got === 1'bx || got + tol - exp > 2 * tol) bad(got, exp);
  endtask : near
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic span(input logic lvl, output logic [15:0] k);
    k = 16'h0;
    while (pwm_output_pin === lvl && k < 16'd400) begin
      cyc(1);
      k++;
    end
  endtask : span
  // load a counter and clear its flags in the same cycle
  task automatic ld(ref tsw_cnt_ctl_t x, input logic [1:0] m, input logic ev, input logic [15:0] v);
    x.run = 1'b0;
    x.mode = m;
    x.event_mode = ev;
    x.load_value = v;
    x.load = 1'b1;
    x.flag_clear = 1'b1;
    cyc(1);
    x.load = 1'b0;
    x.flag_clear = 1'b0;
    x.run = 1'b1;
  endtask : ld
  // start a wake countdown and count slow edges until it fires
  task automatic wake_run(input logic [7:0] v, input logic lg, input logic [15:0] exp);
    logic [15:0] e;
    logic prev;
    int k;
    e = 16'h0;
    k = 0;
    wake_value = v;
    wake_long_range = lg;
    wake_start = 1'b1;
    cyc(1);
    wake_start = 1'b0;
    while (wake_event !== 1'b1 && k < 60000) begin
      prev = slow_osc_pin;
      cyc(1);
      k++;
      if (slow_osc_pin && !prev) e++;
    end
    near(e, exp, 16'h2);
    chk(16'(wake_busy), 16'h0);
    // let an edge pass so a following start is a fresh pulse
    cyc(1);
  endtask : wake_run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////
  // watchdog: the long wake alone takes about 51k cycles
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    conclude();
  end

  // main sequence
  initial begin
    cyc(16);
    rst = 1'b0;
    chk(wake_cal, CAL_RESET);
    chk(gpt_count, 16'h0);
    gpt_slow_rate = 1'b1;
    gpt_run = 1'b1;
    cyc(3000);
    near(gpt_count, 16'd3, 16'd1);
    gpt_run = 1'b0;
    cyc(20);
    gpt_slow_rate = 1'b0;
    gpt_run = 1'b1;
    cyc(1000);
    near(gpt_count, 16'h80a0, 16'd2);
    // stopping preloads the start value; each wrap reloads it and sets the flag
    gpt_run = 1'b0;
    gpt_reload = 16'hfff0;
    gpt_irq_enable = 1'b0;
    cyc(8);
    chk(gpt_count, 16'hfff0);
    gpt_run = 1'b1;
    repeat (2) begin
      n = 0;
      while (gpt_flag !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      chk(gpt_count, 16'hfff0);
      chk(16'({gpt_flag, gpt_irq}), {14'h0, 1'b1, gpt_irq_enable});
      gpt_irq_enable = 1'b1;
      gpt_flag_clear = 1'b1;
      cyc(1);
      gpt_flag_clear = 1'b0;
      chk(16'({gpt_flag, gpt_irq}), 16'h0);
    end
    pwm_enable = 1'b1;
    span(1'b0, c);
    span(1'b1, c);
    span(1'b0, c);
    near(c, 16'd31, 16'd1);
    span(1'b1, c);
    near(c, 16'd18, 16'd1);
    pwm_enable = 1'b0;
    cyc(2);
    chk(16'(pwm_output_pin), 16'h0);
    ld(counter_a_ctl, MODE_16BIT, 1'b0, 16'h0);
    cyc(100);
    near(counter_a_sts.count, 16'd64, 16'd2);
    // rollover in each counting mode
    for (int m = 0; m < 3; m++) begin
      ld(counter_a_ctl, 2'(m), 1'b0, mv[m]);
      chk(16'(counter_a_sts.overflow), 16'h0);
      n = 0;
      while (counter_a_sts.overflow !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      chk(16'({counter_a_sts.overflow, counter_a_sts.irq}), 16'h3);
      chk(counter_a_sts.count & 16'hff00, me[m]);
    end
    ld(counter_a_ctl, MODE_HOLD, 1'b0, 16'h1234);
    cyc(50);
    chk(counter_a_sts.count, 16'h1234);
    // event mode: each pin feeds only its own counter
    ld(counter_a_ctl, MODE_16BIT, 1'b1, 16'h0);
    ld(counter_b_ctl, MODE_16BIT, 1'b1, 16'h0);
    repeat (5) begin
      counter_b_event_pin = 1'b0;
      cyc(8);
      counter_b_event_pin = 1'b1;
      cyc(8);
    end
    repeat (3) begin
      counter_a_event_pin = 1'b0;
      cyc(8);
      counter_a_event_pin = 1'b1;
      cyc(8);
    end
    chk(counter_b_sts.count, 16'd5);
    chk(counter_a_sts.count, 16'd3);
    chk(wake_cal, 16'd20);
    wake_run(8'h0, 1'b0, 16'd0);
    wake_run(8'h3, 1'b0, 16'd120);
    wake_run(8'h1, 1'b1, 16'd5120);
    conclude();
  end
endmodule : tsw_timer_set_test
